/* File: design/l2_params.svh */
`ifndef L2_PARAMS_SVH
`define L2_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_AGE 8'h04
`define OFS_KEY_LO 8'h08
`define OFS_KEY_HI 8'h0c
`define OFS_KEY_PORTS 8'h10
`define OFS_CMD 8'h14
`define OFS_STATUS 8'h18
`define OFS_RES_LO 8'h1c
`define OFS_RES_HI 8'h20
`define OFS_RES_PORTS 8'h24
`define OFS_RES_IDX 8'h28
`define OFS_QSTAT 8'h2c

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_SNOOP 0
`define CTRL_QUERIER 1
`define CTRL_FASTLEAVE 2
`define CTRL_RST 32'h0000_0000
`define AGE_RST 16'h012c

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define TABLE_DEPTH 8192
`define NUM_PORTS 26
`define NUM_GROUPS 16
`define CLK_HZ 25000000
`define QUERY_PERIOD_S 16'd125
`define LEAVE_WAIT_MS 1000

// ----------------------------------------
// IGMP codes and addresses
// ----------------------------------------
`define IGMP_QUERY 8'h11
`define IGMP_REPORT_V2 8'h16
`define IGMP_REPORT_V1 8'h12
`define IGMP_LEAVE 8'h17
`define ALL_HOSTS 32'he000_0001
`define MCAST_LO 32'he000_0000
`define MCAST_HI 32'hefff_ffff
`define QUERY_TTL 8'h01

`endif

/* File: design/l2_pkg.sv */
package l2_pkg;
	typedef enum logic [1:0] {S_INIT, S_IDLE, S_SCAN, S_APPLY} scan_state_t;
	typedef enum logic [1:0] {K_FRAME, K_CMD, K_AGE} scan_kind_t;
	typedef enum logic [2:0] {
		OP_NONE, OP_ADD_STATIC, OP_ADD_FILTER, OP_DELETE, OP_CLEAR_PORT, OP_NEXT, OP_RESTART
	} op_t;
	typedef enum logic [2:0] {
		IG_NONE, IG_GEN_QUERY, IG_GRP_QUERY, IG_REPORT_V1, IG_REPORT_V2, IG_LEAVE, IG_OTHER
	} igmp_class_t;

	typedef struct packed {
		logic valid;
		logic static_e;
		logic filter;
		logic hit;
		logic [11:0] vlan_identifier;
		logic [47:0] addr;
		logic [31:0] ports;
	} entry_t;

	typedef struct packed {
		logic [4:0] port;
		logic [47:0] source_station_address;
		logic [47:0] dst;
		logic [11:0] vlan_identifier;
		logic ipv4;
		logic [31:0] dst_ip;
		logic igmp;
		logic [63:0] igmp_hdr;
	} frame_t;

	typedef struct packed {
		logic drop;
		logic to_cpu;
		igmp_class_t igmp_class;
		logic [31:0] ports;
	} fwd_t;

	typedef struct packed {
		logic [7:0] type_code;
		logic [7:0] ttl;
		logic [31:0] dst_ip;
		logic [31:0] group;
		logic [31:0] ports;
	} query_t;
endpackage

/* File: design/l2_address_table_igmp_snoop.sv */
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "l2_params.svh"
module l2_address_table_igmp_snoop import l2_pkg::*; #(
	parameter int DEPTH = `TABLE_DEPTH,
	parameter int NPORTS = `NUM_PORTS,
	parameter int GROUPS = `NUM_GROUPS,
	parameter int SEC_CYC = `CLK_HZ,
	parameter int LEAVE_CYC = `LEAVE_WAIT_MS * (`CLK_HZ / 1000)
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic frame_valid_i,
	input wire frame_t frame_i,
	output logic frame_ready_o,
	output logic fwd_valid_o,
	output fwd_t fwd_o,
	output logic query_valid_o,
	output query_t query_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int GW = (GROUPS > 1) ? $clog2(GROUPS) : 1;
	localparam logic [31:0] PORT_ALL = 32'((33'h1 << NPORTS) - 33'h1);

	if (NPORTS < 2 || NPORTS > 32 || DEPTH < 2 || DEPTH > 32768 || GROUPS < 1
		|| SEC_CYC < 1 || LEAVE_CYC < 1) begin : g_bad_params
		$error("unsupported parameter values");
	end

	scan_state_t state, next_state;
	scan_kind_t kind, next_kind;
	op_t op;
	entry_t mem [DEPTH];
	entry_t ent, b_ent, mem_wd;
	entry_t res;
	frame_t fr;
	logic [AW-1:0] idx, s_idx, k_idx, fr_idx, b_idx, mem_wa, res_idx;
	logic [AW:0] cnt;
	logic s_hit, s_stat, d_hit, f_hit, k_hit, fr_ok, b_hit;
	logic mem_we, cnt_up, cnt_dn, busy, full, restart_wr, found, cur_first;
	logic [31:0] d_ports, key_ports, rd_val, sec_cnt, pend_cnt, in_bit, others;
	logic [47:0] key_addr;
	logic [11:0] key_vlan;
	logic [59:0] cursor;
	logic [4:0] cport;
	logic snoop_en, querier_en, fastleave_en, cmd_pend, sec_tick, age_req;
	logic [15:0] age_s, age_cnt, q_sec, q_count;
	logic take, wr_ph, rd_ph;
	logic [7:0] ph_addr;
	logic [GROUPS-1:0] g_valid, g_ans;
	logic [31:0] g_ip [GROUPS];
	logic [31:0] g_mem [GROUPS];
	logic g_hit, g_free;
	logic [GW-1:0] g_idx, g_fidx, pend_grp;
	logic [4:0] pend_port;
	logic pend_valid, q_due, q_fire, lv_query, ig_apply, is_report, is_leave, mcast;
	logic [7:0] ig_type;
	logic [31:0] ig_group, gkey;
	igmp_class_t ig_class;

	// ----------------------------------------
	// AHB-Lite slave: writes zero wait, reads one wait
	// ----------------------------------------
	assign take = hsel_i && htrans_i[1] && hready_i;
	assign busy = cmd_pend || (kind == K_CMD && state != S_IDLE);
	assign restart_wr = wr_ph && ph_addr == `OFS_CMD && !busy
		&& op_t'(hwdata_i[2:0]) == OP_RESTART;
	assign full = cnt == (AW+1)'(DEPTH);

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			wr_ph <= 1'b0;
			rd_ph <= 1'b0;
			ph_addr <= 8'h00;
			hreadyout_o <= 1'b1;
			hrdata_o <= 32'h0000_0000;
			hresp_o <= 1'b0;
		end else begin
			wr_ph <= take && hwrite_i;
			rd_ph <= take && !hwrite_i;
			if (take) begin
				ph_addr <= haddr_i[7:0];
			end
			// Wait state lets a write just before a read land first
			hreadyout_o <= !(take && !hwrite_i);
			if (rd_ph) begin
				hrdata_o <= rd_val;
			end
			hresp_o <= 1'b0;
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		if (ph_addr == `OFS_CTRL) begin
			rd_val = {29'h0, fastleave_en, querier_en, snoop_en};
		end else if (ph_addr == `OFS_AGE) begin
			rd_val = {16'h0, age_s};
		end else if (ph_addr == `OFS_KEY_LO) begin
			rd_val = key_addr[31:0];
		end else if (ph_addr == `OFS_KEY_HI) begin
			rd_val = {4'h0, key_vlan, key_addr[47:32]};
		end else if (ph_addr == `OFS_KEY_PORTS) begin
			rd_val = key_ports;
		end else if (ph_addr == `OFS_STATUS) begin
			rd_val = {16'(cnt), 12'h0, pend_valid, found, full, busy};
		end else if (ph_addr == `OFS_RES_LO) begin
			rd_val = res.addr[31:0];
		end else if (ph_addr == `OFS_RES_HI) begin
			rd_val = {res.valid, res.filter, res.static_e, 1'b0, res.vlan_identifier,
				res.addr[47:32]};
		end else if (ph_addr == `OFS_RES_PORTS) begin
			rd_val = res.ports;
		end else if (ph_addr == `OFS_RES_IDX) begin
			rd_val = 32'(res_idx);
		end else if (ph_addr == `OFS_QSTAT) begin
			rd_val = {16'h0, q_count};
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			{fastleave_en, querier_en, snoop_en} <= 3'(`CTRL_RST);
			age_s <= `AGE_RST;
			key_addr <= 48'h0;
			key_vlan <= 12'h000;
			key_ports <= 32'h0000_0000;
			cmd_pend <= 1'b0;
			op <= OP_NONE;
			cport <= 5'h00;
		end else begin
			if (state == S_IDLE && next_state == S_SCAN && next_kind == K_CMD) begin
				cmd_pend <= 1'b0;
			end
			if (wr_ph) begin
				if (ph_addr == `OFS_CTRL) begin
					snoop_en <= hwdata_i[`CTRL_SNOOP];
					querier_en <= hwdata_i[`CTRL_QUERIER];
					fastleave_en <= hwdata_i[`CTRL_FASTLEAVE];
				end else if (ph_addr == `OFS_AGE) begin
					age_s <= hwdata_i[15:0];
				end else if (ph_addr == `OFS_KEY_LO) begin
					key_addr[31:0] <= hwdata_i;
				end else if (ph_addr == `OFS_KEY_HI) begin
					key_addr[47:32] <= hwdata_i[15:0];
					key_vlan <= hwdata_i[27:16];
				end else if (ph_addr == `OFS_KEY_PORTS) begin
					key_ports <= hwdata_i;
				end else if (ph_addr == `OFS_CMD && !busy) begin
					// Commands while busy are dropped; software polls busy
					op <= op_t'(hwdata_i[2:0]);
					cport <= hwdata_i[12:8];
					cmd_pend <= hwdata_i[2:0] != 3'h0 && !restart_wr;
				end
			end
		end
	end

	// ----------------------------------------
	// Table scan engine
	// ----------------------------------------
	// One entry per cycle keeps a single memory port; a frame costs DEPTH+2 cycles.
	assign ent = mem[idx];
	assign in_bit = 32'h1 << fr.port;
	assign others = PORT_ALL & ~in_bit;

	always_comb begin
		next_kind = frame_valid_i ? K_FRAME : (cmd_pend ? K_CMD : K_AGE);
		next_state = state;
		case (state)
			S_INIT, S_SCAN: begin
				if (idx == AW'(DEPTH - 1)) begin
					next_state = (state == S_INIT) ? S_IDLE : S_APPLY;
				end
			end
			S_IDLE: begin
				if (frame_valid_i || cmd_pend || age_req) begin
					next_state = S_SCAN;
				end
			end
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state <= S_INIT;
			kind <= K_AGE;
			idx <= '0;
			fr <= '0;
			frame_ready_o <= 1'b0;
			{s_hit, s_stat, d_hit, f_hit, k_hit, fr_ok, b_hit} <= 7'h00;
			{s_idx, k_idx, fr_idx, b_idx} <= '0;
			d_ports <= 32'h0000_0000;
			b_ent <= '0;
		end else begin
			state <= next_state;
			frame_ready_o <= next_state == S_IDLE;
			idx <= (state == next_state && state != S_IDLE) ? idx + AW'(1) : '0;
			if (state == S_IDLE && next_state == S_SCAN) begin
				kind <= next_kind;
				if (next_kind == K_FRAME) begin
					fr <= frame_i;
				end
				{s_hit, s_stat, d_hit, f_hit, k_hit, fr_ok, b_hit} <= 7'h00;
			end
			if (state == S_SCAN) begin
				if (ent.valid && !ent.filter && ent.vlan_identifier == fr.vlan_identifier) begin
					if (ent.addr == fr.source_station_address) begin
						s_hit <= 1'b1;
						s_stat <= ent.static_e;
						s_idx <= idx;
					end
					if (ent.addr == fr.dst) begin
						d_hit <= 1'b1;
						d_ports <= ent.ports;
					end
				end
				if (ent.valid && ent.filter && ent.vlan_identifier == fr.vlan_identifier
					&& (ent.addr == fr.source_station_address || ent.addr == fr.dst)) begin
					f_hit <= 1'b1;
				end
				if (ent.valid && ent.addr == key_addr && ent.vlan_identifier == key_vlan) begin
					k_hit <= 1'b1;
					k_idx <= idx;
				end
				if (!ent.valid && !fr_ok) begin
					fr_ok <= 1'b1;
					fr_idx <= idx;
				end
				if (ent.valid && (cur_first || {ent.vlan_identifier, ent.addr} > cursor)
					&& (!b_hit || {ent.vlan_identifier, ent.addr}
					< {b_ent.vlan_identifier, b_ent.addr})) begin
					b_hit <= 1'b1;
					b_idx <= idx;
					b_ent <= ent;
				end
			end
		end
	end

	always_comb begin
		mem_we = 1'b0;
		mem_wa = idx;
		mem_wd = ent;
		cnt_up = 1'b0;
		if (state == S_INIT) begin
			mem_we = 1'b1;
			mem_wd = '0;
		end else if (state == S_SCAN && kind == K_AGE && ent.valid && !ent.static_e
			&& !ent.filter) begin
			// Two-pass hit bit: removal falls between one and two intervals
			mem_we = 1'b1;
			mem_wd.hit = 1'b0;
			mem_wd.valid = ent.hit;
		end else if (state == S_SCAN && kind == K_CMD && op == OP_CLEAR_PORT && ent.valid
			&& !ent.static_e && !ent.filter && ent.ports[cport]) begin
			mem_we = 1'b1;
			mem_wd.valid = 1'b0;
		end else if (state == S_APPLY && kind == K_FRAME && !f_hit) begin
			mem_wd = '{valid: 1'b1, static_e: 1'b0, filter: 1'b0, hit: 1'b1,
				vlan_identifier: fr.vlan_identifier, addr: fr.source_station_address,
				ports: in_bit};
			if (s_hit) begin
				mem_we = !s_stat;
				mem_wa = s_idx;
			end else begin
				mem_we = fr_ok;
				mem_wa = fr_idx;
				cnt_up = fr_ok;
			end
		end else if (state == S_APPLY && kind == K_CMD
			&& (op == OP_ADD_STATIC || op == OP_ADD_FILTER)) begin
			mem_wd = '{valid: 1'b1, static_e: op == OP_ADD_STATIC, filter: op == OP_ADD_FILTER,
				hit: 1'b0, vlan_identifier: key_vlan, addr: key_addr,
				ports: key_ports & PORT_ALL};
			mem_we = k_hit || fr_ok;
			mem_wa = k_hit ? k_idx : fr_idx;
			cnt_up = !k_hit && fr_ok;
		end else if (state == S_APPLY && kind == K_CMD && op == OP_DELETE) begin
			mem_wd = '0;
			mem_we = k_hit;
			mem_wa = k_idx;
		end
		cnt_dn = mem_we && !mem_wd.valid && state != S_INIT;
	end

	always_ff @(posedge mclk_i) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cnt <= '0;
		end else if (cnt_up && !cnt_dn) begin
			cnt <= cnt + (AW+1)'(1);
		end else if (cnt_dn && !cnt_up) begin
			cnt <= cnt - (AW+1)'(1);
		end
	end

	// ----------------------------------------
	// Command results and sorted walk
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			res <= '0;
			res_idx <= '0;
			cursor <= 60'h0;
			cur_first <= 1'b1;
			found <= 1'b0;
		end else if (restart_wr) begin
			cur_first <= 1'b1;
		end else if (state == S_APPLY && kind == K_CMD) begin
			case (op)
				OP_NEXT: begin
					found <= b_hit;
					if (b_hit) begin
						res <= b_ent;
						res_idx <= b_idx;
						cursor <= {b_ent.vlan_identifier, b_ent.addr};
						cur_first <= 1'b0;
					end
				end
				OP_DELETE: found <= k_hit;
				OP_CLEAR_PORT: found <= 1'b1;
				default: found <= k_hit || fr_ok;
			endcase
		end
	end

	// ----------------------------------------
	// Second tick and aging schedule
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			sec_cnt <= 32'h0000_0000;
			sec_tick <= 1'b0;
			age_cnt <= 16'h0000;
			age_req <= 1'b0;
		end else begin
			sec_tick <= sec_cnt == 32'(SEC_CYC - 1);
			sec_cnt <= (sec_cnt == 32'(SEC_CYC - 1)) ? 32'h0000_0000 : sec_cnt + 32'h1;
			if (state == S_IDLE && next_state == S_SCAN && next_kind == K_AGE) begin
				age_req <= 1'b0;
			end
			if (sec_tick && age_s != 16'h0000) begin
				if (age_cnt >= age_s - 16'h0001) begin
					age_cnt <= 16'h0000;
					age_req <= 1'b1;
				end else begin
					age_cnt <= age_cnt + 16'h0001;
				end
			end
		end
	end

	// ----------------------------------------
	// IGMP decode and group table
	// ----------------------------------------
	assign ig_type = fr.igmp_hdr[63:56];
	assign ig_group = fr.igmp_hdr[31:0];

	always_comb begin
		case (ig_type)
			`IGMP_QUERY: ig_class = (ig_group == 32'h0) ? IG_GEN_QUERY : IG_GRP_QUERY;
			`IGMP_REPORT_V2: ig_class = IG_REPORT_V2;
			`IGMP_REPORT_V1: ig_class = IG_REPORT_V1;
			`IGMP_LEAVE: ig_class = IG_LEAVE;
			default: ig_class = IG_OTHER;
		endcase
		if (!fr.igmp) begin
			ig_class = IG_NONE;
		end
	end

	assign gkey = fr.igmp ? ig_group : fr.dst_ip;
	assign ig_apply = state == S_APPLY && kind == K_FRAME && snoop_en && fr.igmp && !f_hit;
	assign is_report = ig_class == IG_REPORT_V1 || ig_class == IG_REPORT_V2;
	assign is_leave = ig_class == IG_LEAVE;
	assign lv_query = ig_apply && is_leave && g_hit && !fastleave_en && !pend_valid;
	assign q_fire = q_due && !lv_query;
	assign mcast = snoop_en && fr.ipv4 && !fr.igmp && fr.dst_ip >= `MCAST_LO
		&& fr.dst_ip <= `MCAST_HI;

	always_comb begin
		g_hit = 1'b0;
		g_idx = '0;
		g_free = 1'b0;
		g_fidx = '0;
		for (int i = 0; i < GROUPS; i++) begin
			if (g_valid[i] && g_ip[i] == gkey && !g_hit) begin
				g_hit = 1'b1;
				g_idx = GW'(i);
			end
			if (!g_valid[i] && !g_free) begin
				g_free = 1'b1;
				g_fidx = GW'(i);
			end
		end
	end

	// Later assignments win, so a report beats a same-cycle removal
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			g_valid <= '0;
			g_ans <= '0;
			for (int i = 0; i < GROUPS; i++) begin
				g_ip[i] <= 32'h0000_0000;
				g_mem[i] <= 32'h0000_0000;
			end
		end else begin
			if (q_fire) begin
				g_valid <= g_valid & g_ans;
				g_ans <= '0;
			end
			if (pend_valid && pend_cnt == 32'h0) begin
				g_mem[pend_grp][pend_port] <= 1'b0;
			end
			if (ig_apply && is_report) begin
				if (g_hit) begin
					g_valid[g_idx] <= 1'b1;
					g_mem[g_idx][fr.port] <= 1'b1;
					g_ans[g_idx] <= 1'b1;
				end else if (g_free) begin
					g_valid[g_fidx] <= 1'b1;
					g_ans[g_fidx] <= 1'b1;
					g_ip[g_fidx] <= ig_group;
					g_mem[g_fidx] <= in_bit;
				end
			end else if (ig_apply && is_leave && g_hit && fastleave_en) begin
				g_mem[g_idx][fr.port] <= 1'b0;
			end
		end
	end

	// One leave wait at a time; a second leave while one is pending is ignored
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			pend_valid <= 1'b0;
			pend_cnt <= 32'h0000_0000;
			pend_grp <= '0;
			pend_port <= 5'h00;
		end else if (pend_valid) begin
			if (pend_cnt == 32'h0 || (ig_apply && is_report && g_hit && g_idx == pend_grp
				&& fr.port == pend_port)) begin
				pend_valid <= 1'b0;
			end else begin
				pend_cnt <= pend_cnt - 32'h1;
			end
		end else if (lv_query) begin
			pend_valid <= 1'b1;
			pend_cnt <= 32'(LEAVE_CYC - 1);
			pend_grp <= g_idx;
			pend_port <= fr.port;
		end
	end

	// ----------------------------------------
	// Query origination
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			query_valid_o <= 1'b0;
			query_o <= '0;
			q_due <= 1'b0;
			q_sec <= 16'h0000;
			q_count <= 16'h0000;
		end else begin
			query_valid_o <= 1'b0;
			if (!querier_en) begin
				q_sec <= 16'h0000;
				q_due <= 1'b0;
			end else if (sec_tick) begin
				if (q_sec >= `QUERY_PERIOD_S - 16'd1) begin
					q_sec <= 16'h0000;
					q_due <= 1'b1;
				end else begin
					q_sec <= q_sec + 16'h0001;
				end
			end
			if (lv_query) begin
				query_valid_o <= 1'b1;
				query_o <= '{type_code: `IGMP_QUERY, ttl: `QUERY_TTL, dst_ip: ig_group,
					group: ig_group, ports: in_bit};
			end else if (q_fire) begin
				q_due <= 1'b0;
				query_valid_o <= 1'b1;
				query_o <= '{type_code: `IGMP_QUERY, ttl: `QUERY_TTL, dst_ip: `ALL_HOSTS,
					group: 32'h0, ports: PORT_ALL};
				q_count <= q_count + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Forwarding decision
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			fwd_valid_o <= 1'b0;
			fwd_o <= '0;
		end else begin
			fwd_valid_o <= state == S_APPLY && kind == K_FRAME;
			if (state == S_APPLY && kind == K_FRAME) begin
				fwd_o.drop <= f_hit;
				fwd_o.to_cpu <= snoop_en && fr.igmp && !f_hit;
				fwd_o.igmp_class <= ig_class;
				if (f_hit) begin
					fwd_o.ports <= 32'h0000_0000;
				end else if (mcast) begin
					fwd_o.ports <= g_hit ? (g_mem[g_idx] & others) : 32'h0;
				end else if (d_hit) begin
					fwd_o.ports <= d_ports & others;
				end else begin
					fwd_o.ports <= others;
				end
			end
		end
	end
endmodule

/* File: test/l2_snoop_properties.sv */
`timescale 1ns/1ps
module l2_snoop_properties import l2_pkg::*; #(
	parameter int DEPTH = 16
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic frame_valid_i,
	input wire logic frame_ready_o,
	input wire logic fwd_valid_o,
	input wire logic query_valid_o,
	input wire query_t query_o
);
	localparam int LAT1 = DEPTH + 1;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	// ----
	// Bus and frame handshakes, decision and query outputs
	// ----
	sequence bus_take; hsel_i && htrans_i[1] && hready_i; endsequence
	sequence one_wait; !hreadyout_o ##1 hreadyout_o; endsequence
	sequence fr_take; frame_valid_i && frame_ready_o; endsequence
	chk_read_wait: assert property (bus_take and !hwrite_i |=> one_wait)
		else $error("read wait state wrong");
	chk_write_nowait: assert property (bus_take and hwrite_i |=> hreadyout_o)
		else $error("write stalled");
	chk_resp_okay: assert property (!hresp_o) else $error("error response");
	chk_fwd_latency: assert property (fr_take |=> !frame_ready_o ##LAT1 fwd_valid_o)
		else $error("decision late or missing");
	chk_fwd_pulse: assert property (fwd_valid_o |=> !fwd_valid_o) else $error("long decision");
	chk_query_pulse: assert property (query_valid_o |=> !query_valid_o) else $error("long query");
	chk_query_ttl: assert property (query_valid_o |-> query_o.ttl == 8'h01 &&
		query_o.type_code == 8'h11) else $error("query ttl or type wrong");
	chk_general_dst: assert property (query_valid_o && query_o.group == '0 |->
		query_o.dst_ip == 32'he000_0001) else $error("general query address wrong");
endmodule

/* File: test/port_partner.sv */
`timescale 1ns/1ps
module port_partner import l2_pkg::*; (
	input wire logic mclk_i,
	input wire logic ready_i,
	input wire logic fwd_valid_i,
	input wire fwd_t fwd_i,
	output logic valid_o,
	output frame_t frame_o
);
	initial begin
		valid_o = 1'b0;
		frame_o = '0;
	end
	task automatic send(input frame_t f, output fwd_t r);
		@(posedge mclk_i);
		valid_o <= 1'b1;
		frame_o <= f;
		do @(posedge mclk_i); while (ready_i !== 1'b1);
		valid_o <= 1'b0;
		// Released descriptor shows junk, so stale data cannot pass
		frame_o <= ~f;
		// No local limit: a lost decision runs into the bench timeout
		do @(posedge mclk_i); while (fwd_valid_i !== 1'b1);
		r = fwd_i;
	endtask
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top import l2_pkg::*;;
	localparam logic [31:0] ALL = 32'h03ff_ffff, GRP = 32'he100_0005;
	localparam logic [47:0] MA = 48'ha1, MB = 48'hb2, MC = 48'hc3, MD = 48'hd4, MM = 48'h01005e000005;
	logic mclk_i = 1'b0, sys_rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, hready_i;
	logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o;
	logic [1:0] htrans_i = '0;
	logic [2:0] hsize_i = 3'b010;
	logic hreadyout_o, hresp_o, frame_valid_i, frame_ready_o, fwd_valid_o, query_valid_o;
	frame_t frame_i;
	fwd_t fwd_o;
	query_t query_o;
	int miscompares = 0, samples_checked = 0, cycles = 0;
	assign hready_i = hreadyout_o;
	always #20 mclk_i = ~mclk_i;
	l2_address_table_igmp_snoop #(.DEPTH(16), .SEC_CYC(20), .LEAVE_CYC(30)) u_dut (.*);
	port_partner u_host (.mclk_i(mclk_i), .ready_i(frame_ready_o), .fwd_valid_i(fwd_valid_o),
		.fwd_i(fwd_o), .valid_o(frame_valid_i), .frame_o(frame_i));
	// ----
	// Shared tasks
	// ----
	task automatic results();
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected at %0t: %h vs %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'b10;
		hwrite_i <= w;
		haddr_i <= {24'h0, a};
		do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'b00;
		hwdata_i <= d;
		do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
		q = hrdata_o;
	endtask
	task automatic cmd(input logic [31:0] op, input logic [47:0] a, input logic [31:0] pm);
		logic [31:0] q;
		bus(1'b1, 8'h08, a[31:0], q);
		bus(1'b1, 8'h0c, {4'h0, 12'h005, a[47:32]}, q);
		bus(1'b1, 8'h10, pm, q);
		bus(1'b1, 8'h14, op, q);
		do bus(1'b0, 8'h18, '0, q); while (q[0] !== 1'b0);
	endtask
	function automatic frame_t mk(input logic [4:0] p, input logic [47:0] s, d,
		input logic [31:0] ip, input logic [7:0] ty, input logic [31:0] g);
		mk = '{p, s, d, 12'h005, ip != 0, ip, ty != 0, {ty, 8'h0a, 16'h0, g}};
	endfunction
	// ----
	// Scenarios
	// ----
	task automatic s_regs();
		logic [31:0] q;
		bus(1'b0, 8'h00, '0, q);
		chk(q, 32'h0);
		bus(1'b0, 8'h04, '0, q);
		chk(q, 32'h12c);
		// Aging off keeps learned entries steady for the later checks
		bus(1'b1, 8'h04, 32'h0, q);
		bus(1'b0, 8'h04, '0, q);
		chk(q, 32'h0);
		bus(1'b0, 8'h3c, '0, q);
		chk(q, 32'h0);
	endtask
	task automatic s_l2();
		fwd_t r;
		u_host.send(mk(5'd3, MA, MB, '0, '0, '0), r);
		chk(r.ports, ALL & ~32'h8);
		u_host.send(mk(5'd1, MB, MA, '0, '0, '0), r);
		chk(r.ports, 32'h8);
		cmd(32'h1, MC, 32'h80);
		u_host.send(mk(5'd2, MC, MA, '0, '0, '0), r);
		u_host.send(mk(5'd1, MB, MC, '0, '0, '0), r);
		chk(r.ports, 32'h80);
		cmd(32'h2, MD, '0);
		u_host.send(mk(5'd1, MD, MA, '0, '0, '0), r);
		chk(r.drop, 1'b1);
		cmd(32'h0304, MA, '0);
		u_host.send(mk(5'd1, MB, MA, '0, '0, '0), r);
		chk(r.ports, ALL & ~32'h2);
		u_host.send(mk(5'd1, MB, MC, '0, '0, '0), r);
		chk(r.ports, 32'h80);
	endtask
	task automatic s_tab();
		fwd_t r;
		logic [31:0] q;
		// Short aging run: dynamic entries go, static and filter stay
		bus(1'b1, 8'h04, 32'h1, q);
		repeat (100) @(posedge mclk_i);
		bus(1'b1, 8'h04, 32'h0, q);
		u_host.send(mk(5'd2, MC, MB, '0, '0, '0), r);
		chk(r.ports, ALL & ~32'h4);
		bus(1'b0, 8'h18, '0, q);
		chk(q[31:16], 16'h2);
		// Larger key in a lower slot shows the walk is sorted, not by index
		cmd(32'h2, 48'he5, '0);
		cmd(32'h6, '0, '0);
		cmd(32'h5, '0, '0);
		bus(1'b0, 8'h1c, '0, q);
		chk(q, 32'hc3);
		bus(1'b0, 8'h20, '0, q);
		chk(q, 32'ha005_0000);
		bus(1'b0, 8'h24, '0, q);
		chk(q, 32'h80);
		bus(1'b0, 8'h28, '0, q);
		chk(q, 32'h2);
		cmd(32'h5, '0, '0);
		bus(1'b0, 8'h1c, '0, q);
		chk(q, 32'hd4);
		cmd(32'h3, MC, '0);
		u_host.send(mk(5'd1, MB, MC, '0, '0, '0), r);
		chk(r.ports, ALL & ~32'h2);
	endtask
	task automatic s_igmp();
		logic [7:0] ty[4] = '{8'h11, 8'h11, 8'h16, 8'h12};
		logic [31:0] g[4] = '{32'h0, GRP, GRP, GRP};
		igmp_class_t c[4] = '{IG_GEN_QUERY, IG_GRP_QUERY, IG_REPORT_V2, IG_REPORT_V1};
		fwd_t r;
		logic [31:0] q;
		bus(1'b1, 8'h00, 32'h1, q);
		foreach (ty[i]) begin
			u_host.send(mk(5'd4, MA, MM, GRP, ty[i], g[i]), r);
			chk(r.to_cpu, 1'b1);
			chk(r.igmp_class, c[i]);
		end
		u_host.send(mk(5'd0, MB, MM, GRP, '0, '0), r);
		chk(r.ports, 32'h10);
		u_host.send(mk(5'd0, MB, MM, 32'hefff_ffff, '0, '0), r);
		chk(r.ports, 32'h0);
		bus(1'b1, 8'h00, 32'h5, q);
		u_host.send(mk(5'd4, MA, MM, GRP, 8'h17, GRP), r);
		chk(r.igmp_class, IG_LEAVE);
		u_host.send(mk(5'd0, MB, MM, GRP, '0, '0), r);
		chk(r.ports, 32'h0);
		bus(1'b1, 8'h00, 32'h1, q);
		u_host.send(mk(5'd4, MA, MM, GRP, 8'h16, GRP), r);
		u_host.send(mk(5'd4, MA, MM, GRP, 8'h17, GRP), r);
		chk(query_valid_o, 1'b1);
		chk(query_o.group, GRP);
		chk(query_o.ports, 32'h10);
		u_host.send(mk(5'd0, MB, MM, GRP, '0, '0), r);
		chk(r.ports, 32'h10);
		repeat (20) @(posedge mclk_i);
		u_host.send(mk(5'd0, MB, MM, GRP, '0, '0), r);
		chk(r.ports, 32'h0);
		bus(1'b1, 8'h00, 32'h0, q);
		u_host.send(mk(5'd0, MB, MM, GRP, '0, '0), r);
		chk(r.ports, ALL & ~32'h1);
	endtask
	task automatic s_query();
		int n;
		logic [31:0] q;
		fwd_t r;
		bus(1'b1, 8'h00, 32'h3, q);
		u_host.send(mk(5'd4, MA, MM, GRP, 8'h16, GRP), r);
		// Answered group survives the first query, not the second
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(posedge mclk_i);
				n++;
			end while (query_valid_o !== 1'b1 && n < 3000);
			chk(query_valid_o, 1'b1);
			chk(query_o.dst_ip, 32'he000_0001);
			chk(query_o.ttl, 32'h1);
			u_host.send(mk(5'd0, MB, MM, GRP, '0, '0), r);
			chk(r.ports, (k == 0) ? 32'h10 : 32'h0);
		end
		bus(1'b0, 8'h2c, '0, q);
		chk(q[15:0], 16'h2);
	endtask
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		s_regs();
		s_l2();
		s_tab();
		s_igmp();
		s_query();
		results();
	end
endmodule
bind l2_address_table_igmp_snoop l2_snoop_properties #(.DEPTH(DEPTH)) u_chk (.*);
